// ---- hw/atdp_top.sv ----
// Auxiliary trigger and direct-mode port with its AXI4-Lite register slave.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module atdp_top (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  // On-board configuration status.
  input  wire logic        cfg_done,
  // Block-transfer word stream from the sequencer.
  input  wire logic        blk_active,
  input  wire logic        blk_valid,
  input  wire logic [31:0] blk_data,
  output logic             blk_ready,
  // Internal bus drive from the inbound buffer.
  output logic [31:0]      internal_bus_io_data_o,
  output logic             internal_bus_io_data_oe,
  // Auxiliary connector pins.
  output logic [3:0]       ttl_out,
  output logic             logic_configured_indicator,
  output logic             key_address_pulse_out_n,
  input  wire logic        aux_interrupt_in_n,
  input  wire logic        inbound_en_n,
  input  wire logic        inbound_latch,
  input  wire logic        outbound_en_n,
  input  wire logic        outbound_latch,
  input  wire logic        dm_wait_n,
  output logic             dm_write_en_n,
  output logic             dm_write_clk,
  input  wire logic [31:0] aux_data_i,
  output logic [31:0]      aux_data_o,
  output logic             aux_data_oe
);
  typedef enum logic [2:0] {
    DM_IDLE  = 3'b001,
    DM_SETUP = 3'b010,
    DM_CLK   = 3'b100
  } atdp_dm_t;

  logic [atdp_pkg::IN_NUM-1:0] in_s;
  logic [31:0] aux_data_s;
  // Bus state.
  logic aw_have, w_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic next_aw_have, next_w_have;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [1:0] next_bresp, next_rresp;
  // Register state.
  logic [2:0] ctrl, next_ctrl;
  logic [3:0] next_ttl;
  logic [atdp_pkg::IRQ_NUM-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask;
  logic [31:0] tx_word, next_tx_word, inb_buf, next_inb_buf, next_aux_o;
  logic irq_n_d, wait_n_d, next_irq, next_key_n, next_cfg_ind;
  logic next_ib_oe, next_aux_oe;
  // Direct-mode state.
  atdp_dm_t dm_state, next_dm_state;
  logic [31:0] dm_word, next_dm_word;
  logic next_blk_ready, next_wr_en_n, next_wr_clk, dm_go;
  logic do_write, do_read, wr_hit, rd_hit;

  // Inputs default high, matching the pull-ups on the pins.
  atdp_sync #(.W(atdp_pkg::IN_NUM), .RST(atdp_pkg::IN_RST)) u_sync_ctl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({dm_wait_n, outbound_latch, outbound_en_n,
               inbound_latch, inbound_en_n, aux_interrupt_in_n}),
    .dout    (in_s)
  );

  // Data from the connector is synchronised before the inbound buffer.
  atdp_sync #(.W(32), .RST(32'h0000_0000)) u_sync_data (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (aux_data_i),
    .dout    (aux_data_s)
  );

  // Output bits are set or cleared per bit; a clear wins over a set.
  genvar g;
  generate
    for (g = 0; g < atdp_pkg::TTL_NUM; g++)
    begin : g_ttl
      assign next_ttl[g] = (do_write && aw_addr == atdp_pkg::OFF_TTL)
                         ? ((ttl_out[g] | w_data[g]) & ~w_data[atdp_pkg::TTL_CLR_LSB+g])
                         : ttl_out[g];
    end
  endgenerate

  // Write and read handshakes, decode and register updates.
  always_comb
  begin
    do_write       = aw_have && w_have && !s_axi_bvalid;
    do_read        = s_axi_arvalid && s_axi_arready;
    wr_hit         = aw_addr <= atdp_pkg::OFF_TX_WORD && aw_addr[1:0] == 2'h0;
    rd_hit         = s_axi_araddr <= atdp_pkg::OFF_RX_WORD && s_axi_araddr[1:0] == 2'h0;
    next_aw_have   = aw_have;
    next_w_have    = w_have;
    next_aw_addr   = aw_addr;
    next_w_data    = w_data;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
    end
    next_bvalid    = s_axi_bvalid && !s_axi_bready;
    next_bresp     = s_axi_bresp;
    if (do_write)
    begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? atdp_pkg::RESP_OKAY : atdp_pkg::RESP_SLVERR;
    end
    next_awready   = !next_aw_have && !next_bvalid;
    next_wready    = !next_w_have && !next_bvalid;
    next_rvalid    = s_axi_rvalid && !s_axi_rready;
    next_rdata     = s_axi_rdata;
    next_rresp     = s_axi_rresp;
    if (do_read)
    begin
      next_rvalid = 1'b1;
      next_rresp  = rd_hit ? atdp_pkg::RESP_OKAY : atdp_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        atdp_pkg::OFF_CTRL:     next_rdata = {29'h0, ctrl};
        atdp_pkg::OFF_TTL:      next_rdata = {28'h0, ttl_out};
        // Synchronised pin levels and the configured indicator; an open interrupt input reads high.
        atdp_pkg::OFF_INPUT:    next_rdata = {23'h0, logic_configured_indicator, 2'h0, in_s};
        atdp_pkg::OFF_IRQ_STAT: next_rdata = {30'h0, irq_stat};
        atdp_pkg::OFF_IRQ_MASK: next_rdata = {30'h0, irq_mask};
        atdp_pkg::OFF_TX_WORD:  next_rdata = tx_word;
        atdp_pkg::OFF_RX_WORD:  next_rdata = inb_buf;
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
    next_arready   = !next_rvalid;
    next_ctrl      = ctrl;
    next_irq_mask  = irq_mask;
    next_tx_word   = tx_word;
    if (do_write && aw_addr == atdp_pkg::OFF_CTRL)
      next_ctrl = w_data[2:0];
    if (do_write && aw_addr == atdp_pkg::OFF_IRQ_MASK)
      next_irq_mask = w_data[atdp_pkg::IRQ_NUM-1:0];
    if (do_write && aw_addr == atdp_pkg::OFF_TX_WORD)
      next_tx_word = w_data;
    // Sticky events; a set in the clearing cycle survives.
    next_irq_stat  = irq_stat;
    if (do_write && aw_addr == atdp_pkg::OFF_IRQ_STAT)
      next_irq_stat = irq_stat & ~w_data[atdp_pkg::IRQ_NUM-1:0];
    if (ctrl[atdp_pkg::CTRL_IRQ_EN] && irq_n_d && !in_s[atdp_pkg::IN_IRQ_N])
      next_irq_stat[atdp_pkg::IRQ_AUX_FALL] = 1'b1;
    if (wait_n_d && !in_s[atdp_pkg::IN_WAIT_N])
      next_irq_stat[atdp_pkg::IRQ_WAIT] = 1'b1;
    next_irq       = |(next_irq_stat & next_irq_mask);
    // Any access to the key address gives one low cycle.
    next_key_n     = !((do_write && aw_addr == atdp_pkg::OFF_KEY)
                    || (do_read && s_axi_araddr == atdp_pkg::OFF_KEY));
    next_cfg_ind   = !cfg_done;
  end

  // Direct-mode sequencing: setup cycle, then rising write clock.
  always_comb
  begin
    dm_go          = ctrl[atdp_pkg::CTRL_DM_EN] && blk_active;
    next_dm_state  = dm_state;
    next_dm_word   = dm_word;
    unique case (dm_state)
      DM_IDLE:
        if (blk_valid && blk_ready)
        begin
          next_dm_state = DM_SETUP;
          next_dm_word  = blk_data;
        end
      DM_SETUP: next_dm_state = DM_CLK;
      DM_CLK:   next_dm_state = DM_IDLE;
    endcase
    // Wait is seen after synchronisation, so up to two words may still pass.
    next_blk_ready = dm_go && in_s[atdp_pkg::IN_WAIT_N] && next_dm_state == DM_IDLE
                     && !(blk_valid && blk_ready);
    next_wr_en_n   = !dm_go;
    next_wr_clk    = next_dm_state == DM_CLK;
  end

  // Data buffers: each follows its source when transparent, holds when latched; in direct mode the outbound word follows the stream whatever the latch.
  always_comb
  begin
    next_inb_buf   = in_s[atdp_pkg::IN_INB_LAT] ? inb_buf : aux_data_s;
    next_ib_oe     = !in_s[atdp_pkg::IN_INB_EN];
    if (dm_go || next_dm_state != DM_IDLE)
      next_aux_o = next_dm_word;
    else
      next_aux_o = in_s[atdp_pkg::IN_OUT_LAT] ? aux_data_o : tx_word;
    next_aux_oe    = !in_s[atdp_pkg::IN_OUT_EN] || dm_go;
  end

  // Registers every next value.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= atdp_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= atdp_pkg::RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      ctrl          <= atdp_pkg::CTRL_RST;
      ttl_out       <= atdp_pkg::TTL_RST;
      irq_stat      <= atdp_pkg::IRQ_RST;
      irq_mask      <= atdp_pkg::IRQ_RST;
      irq           <= 1'b0;
      tx_word       <= 32'h0000_0000;
      inb_buf       <= 32'h0000_0000;
      irq_n_d       <= 1'b1;
      wait_n_d      <= 1'b1;
      key_address_pulse_out_n    <= 1'b1;
      logic_configured_indicator <= 1'b1;
      dm_state      <= DM_IDLE;
      dm_word       <= 32'h0000_0000;
      blk_ready     <= 1'b0;
      dm_write_en_n <= 1'b0; // The pin reads low during reset, then high until direct mode runs.
      dm_write_clk  <= 1'b0;
      aux_data_o    <= 32'h0000_0000;
      aux_data_oe   <= 1'b0;
      internal_bus_io_data_o  <= 32'h0000_0000;
      internal_bus_io_data_oe <= 1'b0;
    end
    else
    begin
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      aw_have       <= next_aw_have;
      w_have        <= next_w_have;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      ctrl          <= next_ctrl;
      ttl_out       <= next_ttl;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      irq           <= next_irq;
      tx_word       <= next_tx_word;
      inb_buf       <= next_inb_buf;
      irq_n_d       <= in_s[atdp_pkg::IN_IRQ_N];
      wait_n_d      <= in_s[atdp_pkg::IN_WAIT_N];
      key_address_pulse_out_n    <= next_key_n;
      logic_configured_indicator <= next_cfg_ind;
      dm_state      <= next_dm_state;
      dm_word       <= next_dm_word;
      blk_ready     <= next_blk_ready;
      dm_write_en_n <= next_wr_en_n;
      dm_write_clk  <= next_wr_clk;
      aux_data_o    <= next_aux_o;
      aux_data_oe   <= next_aux_oe;
      internal_bus_io_data_o  <= next_inb_buf;
      internal_bus_io_data_oe <= next_ib_oe;
    end
  end

  // Checks tying outputs to their causes.
  AST_TTL_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr == atdp_pkg::OFF_TTL && w_data[0] && !w_data[16] |=> ttl_out[0])
    else $error("TTL output one did not set.");
  AST_CFG_IND: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_done |=> !logic_configured_indicator)
    else $error("Configured indicator not low after configuration.");
  AST_KEY_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_read && s_axi_araddr == atdp_pkg::OFF_KEY |=> !key_address_pulse_out_n ##1
    key_address_pulse_out_n)
    else $error("Key pulse not a single low cycle.");
  AST_AUX_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[atdp_pkg::CTRL_IRQ_EN] && $fell(in_s[atdp_pkg::IN_IRQ_N])
    |=> irq_stat[atdp_pkg::IRQ_AUX_FALL])
    else $error("Falling interrupt input did not set the flag.");
  AST_INB_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_s[atdp_pkg::IN_INB_EN] |=> internal_bus_io_data_oe)
    else $error("Inbound path not opened.");
  AST_INB_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    in_s[atdp_pkg::IN_INB_LAT] |=> $stable(inb_buf))
    else $error("Inbound buffer changed while latched.");
  AST_WR_EN: assert property (@(posedge aclk) disable iff (!aresetn)
    dm_go |=> !dm_write_en_n)
    else $error("Write enable not low in direct-mode transfer.");
  AST_WR_CLK: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && blk_ready |=> !dm_write_clk ##1 dm_write_clk && aux_data_o == $past(dm_word))
    else $error("Streamed word not qualified by rising clock.");
  AST_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_s[atdp_pkg::IN_WAIT_N] |=> !blk_ready)
    else $error("Stream not stalled under wait.");
endmodule : atdp_top
`default_nettype wire

// ---- shared/atdp_pkg.sv ----
// Shared constants for the auxiliary trigger and direct-mode port.
package atdp_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_TTL      = 8'h04;
  localparam logic [7:0] OFF_INPUT    = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_KEY      = 8'h14;
  localparam logic [7:0] OFF_TX_WORD  = 8'h18;
  localparam logic [7:0] OFF_RX_WORD  = 8'h1c;
  // Control register fields.
  localparam int CTRL_DM_EN  = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_SEQ_EN = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Output register layout: set bits low, clear bits from CLR_LSB.
  localparam int TTL_NUM     = 4;
  localparam int TTL_CLR_LSB = 16;
  localparam logic [3:0] TTL_RST = 4'h0;
  // Synchronised control inputs, also the input register layout.
  localparam int IN_IRQ_N   = 0;
  localparam int IN_INB_EN  = 1;
  localparam int IN_INB_LAT = 2;
  localparam int IN_OUT_EN  = 3;
  localparam int IN_OUT_LAT = 4;
  localparam int IN_WAIT_N  = 5;
  localparam int IN_NUM     = 6;
  localparam int IN_CFG_RDY = 8;
  localparam logic [5:0] IN_RST = 6'h3f;
  // Interrupt status bits.
  localparam int IRQ_AUX_FALL = 0;
  localparam int IRQ_WAIT     = 1;
  localparam int IRQ_NUM      = 2;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : atdp_pkg

// ---- hw/atdp_sync.sv ----
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module atdp_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Raw and filtered levels.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  // A bit changes only where the second and third stages agree.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
    end
  end

  // The first stage feeds only the second.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1   <= RST;
      s2   <= RST;
      s3   <= RST;
      dout <= RST;
    end
    else
    begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule : atdp_sync
`default_nettype wire

// ---- sim/atdp_card.sv ----
// Model of the auxiliary card that receives the direct-mode word stream.
`timescale 1ns/1ps
`default_nettype none
module atdp_card (
  // Clock, reset and test control.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        stall,
  // Direct-mode connector pins.
  input  wire logic        dm_write_en_n,
  input  wire logic        dm_write_clk,
  input  wire logic [31:0] aux_data_o,
  output logic             dm_wait_n,
  // Received word count and last word.
  output var logic [7:0]   n_words,
  output var logic [31:0]  last_word
);
  logic wclk_q;
  // The card holds the stream off whenever the bench asks it to.
  assign dm_wait_n = !stall;
  // A rising write clock while enabled captures the word, even after wait went low.
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      wclk_q <= 1'b0;
      n_words <= 8'h00;
      last_word <= 32'h0;
    end
    else
    begin
      wclk_q <= dm_write_clk;
      if (dm_write_clk && !wclk_q && !dm_write_en_n)
      begin
        n_words <= n_words + 8'h01;
        last_word <= aux_data_o;
      end
    end
endmodule : atdp_card
`default_nettype wire

// ---- sim/atdp_top_tb_top.sv ----
// Self-checking testbench for the auxiliary trigger and direct-mode port.
`timescale 1ns/1ps
`default_nettype none
module atdp_top_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, blk_data = 32'h0, aux_data_i = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, blk_ready, ind, key_n;
  logic ib_oe, ob_oe, we_n, wclk, dm_wait_n, ok;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, ib_data, ob_data, last_word, rd, n_start;
  logic [3:0] ttl_out;
  logic [7:0] n_words;
  logic cfg_done = 1'b0, blk_active = 1'b0, blk_valid = 1'b0, stall = 1'b0;
  logic irq_n = 1'b1, ib_en_n = 1'b1, ib_lat = 1'b1, ob_en_n = 1'b1, ob_lat = 1'b1;
  int n_mismatch = 0, check_count = 0, key_lows = 0;
  // Clock of 8 ns period.
  always #4 aclk = ~aclk;
  atdp_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .cfg_done(cfg_done), .blk_active(blk_active), .blk_valid(blk_valid),
    .blk_data(blk_data), .blk_ready(blk_ready), .internal_bus_io_data_o(ib_data),
    .internal_bus_io_data_oe(ib_oe), .ttl_out(ttl_out), .logic_configured_indicator(ind),
    .key_address_pulse_out_n(key_n), .aux_interrupt_in_n(irq_n), .inbound_en_n(ib_en_n),
    .inbound_latch(ib_lat), .outbound_en_n(ob_en_n), .outbound_latch(ob_lat),
    .dm_wait_n(dm_wait_n), .dm_write_en_n(we_n), .dm_write_clk(wclk),
    .aux_data_i(aux_data_i), .aux_data_o(ob_data), .aux_data_oe(ob_oe));
  atdp_card card (.aclk(aclk), .aresetn(aresetn), .stall(stall), .dm_write_en_n(we_n),
    .dm_write_clk(wclk), .aux_data_o(ob_data), .dm_wait_n(dm_wait_n),
    .n_words(n_words), .last_word(last_word));
  // Counts cycles in which the key pulse is low.
  always @(posedge aclk)
    if (aresetn && key_n === 1'b0)
      key_lows <= key_lows + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc
  // Write one word; ready and bvalid are sampled before the edge that takes them.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait for the response.
    while (!tb)
    begin
      @(negedge aclk);
      ta = awready & awvalid;
      tw = wready & wvalid;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : axi_wr
  // Read one word and compare its response code.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] r;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Only the watchdog ends a wait for the read data.
    while (!tr)
    begin
      @(negedge aclk);
      ta = arready & arvalid;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : axi_rd
  // Offer one stream word; on refusal the word stays offered.
  task automatic blk_send(input logic [31:0] w, input int lim, output logic t);
    int n;
    t = 1'b0;
    n = 0;
    @(posedge aclk);
    blk_valid <= 1'b1;
    blk_data <= w;
    while (!t && n < lim)
    begin
      @(negedge aclk);
      t = blk_ready;
      @(posedge aclk);
      n++;
    end
    if (t)
      blk_valid <= 1'b0;
  endtask : blk_send
  // Pulses the interrupt input low and back high.
  task automatic aux_fall();
    irq_n <= 1'b0;
    wait_cyc(10);
    irq_n <= 1'b1;
    wait_cyc(10);
  endtask : aux_fall
  // Main sequence.
  initial
  begin
    repeat (1) @(posedge aclk);
    @(negedge aclk);
    chk({28'h0, ttl_out}, 32'h0);
    chk({31'h0, ind}, 32'h1);
    chk({30'h0, we_n, key_n}, 32'h1);
    @(posedge aclk);
    aresetn <= 1'b1;
    cfg_done <= 1'b1;
    wait_cyc(10);
    chk({31'h0, ind}, 32'h0);
    axi_wr(atdp_pkg::OFF_CTRL, 32'h0, atdp_pkg::RESP_OKAY);
    axi_wr(atdp_pkg::OFF_TTL, 32'hf, atdp_pkg::RESP_OKAY);
    axi_wr(atdp_pkg::OFF_TTL, 32'h50005, atdp_pkg::RESP_OKAY);
    wait_cyc(2);
    chk({28'h0, ttl_out}, 32'ha);
    axi_rd(atdp_pkg::OFF_TTL, rd, atdp_pkg::RESP_OKAY);
    chk(rd & 32'hf, 32'ha);
    axi_wr(8'h40, 32'h1, atdp_pkg::RESP_SLVERR);
    axi_rd(8'h40, rd, atdp_pkg::RESP_SLVERR);
    axi_wr(atdp_pkg::OFF_KEY, 32'h1, atdp_pkg::RESP_OKAY);
    wait_cyc(3);
    chk(32'(key_lows), 32'h1);
    axi_rd(atdp_pkg::OFF_KEY, rd, atdp_pkg::RESP_OKAY);
    wait_cyc(3);
    chk(32'(key_lows), 32'h2);
    axi_rd(atdp_pkg::OFF_INPUT, rd, atdp_pkg::RESP_OKAY);
    chk(rd & 32'h13f, 32'h3f);
    axi_wr(atdp_pkg::OFF_CTRL, 32'h2, atdp_pkg::RESP_OKAY);
    axi_wr(atdp_pkg::OFF_IRQ_MASK, 32'h1, atdp_pkg::RESP_OKAY);
    irq_n <= 1'b0;
    wait_cyc(10);
    chk({31'h0, irq}, 32'h1);
    axi_rd(atdp_pkg::OFF_INPUT, rd, atdp_pkg::RESP_OKAY);
    chk(rd & 32'h1, 32'h0);
    irq_n <= 1'b1;
    axi_wr(atdp_pkg::OFF_IRQ_STAT, 32'h1, atdp_pkg::RESP_OKAY);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0);
    axi_wr(atdp_pkg::OFF_IRQ_MASK, 32'h0, atdp_pkg::RESP_OKAY);
    aux_fall();
    chk({31'h0, irq}, 32'h0);
    axi_rd(atdp_pkg::OFF_IRQ_STAT, rd, atdp_pkg::RESP_OKAY);
    chk(rd & 32'h1, 32'h1);
    axi_wr(atdp_pkg::OFF_IRQ_STAT, 32'h3, atdp_pkg::RESP_OKAY);
    axi_wr(atdp_pkg::OFF_CTRL, 32'h0, atdp_pkg::RESP_OKAY);
    aux_fall();
    axi_rd(atdp_pkg::OFF_IRQ_STAT, rd, atdp_pkg::RESP_OKAY);
    chk(rd & 32'h1, 32'h0);
    // Inbound path, sequencer left disabled by the control write above.
    ib_lat <= 1'b0;
    ib_en_n <= 1'b0;
    aux_data_i <= 32'h1234abcd;
    wait_cyc(10);
    chk({31'h0, ib_oe}, 32'h1);
    chk(ib_data, 32'h1234abcd);
    axi_rd(atdp_pkg::OFF_RX_WORD, rd, atdp_pkg::RESP_OKAY);
    chk(rd, 32'h1234abcd);
    ib_lat <= 1'b1;
    wait_cyc(10);
    aux_data_i <= 32'h0f0f0f0f;
    wait_cyc(10);
    chk(ib_data, 32'h1234abcd);
    ib_en_n <= 1'b1;
    wait_cyc(10);
    chk({31'h0, ib_oe}, 32'h0);
    // Outbound path from the transmit word.
    axi_wr(atdp_pkg::OFF_TX_WORD, 32'h5a5a0001, atdp_pkg::RESP_OKAY);
    ob_lat <= 1'b0;
    ob_en_n <= 1'b0;
    wait_cyc(10);
    chk({31'h0, ob_oe}, 32'h1);
    chk(ob_data, 32'h5a5a0001);
    ob_lat <= 1'b1;
    wait_cyc(10);
    axi_wr(atdp_pkg::OFF_TX_WORD, 32'h5a5a0002, atdp_pkg::RESP_OKAY);
    wait_cyc(10);
    chk(ob_data, 32'h5a5a0001);
    ob_lat <= 1'b0;
    wait_cyc(10);
    chk(ob_data, 32'h5a5a0002);
    ob_en_n <= 1'b1;
    wait_cyc(10);
    chk({31'h0, ob_oe}, 32'h0);
    // Direct-mode stream with a stall from the card.
    axi_wr(atdp_pkg::OFF_CTRL, 32'h1, atdp_pkg::RESP_OKAY);
    blk_active <= 1'b1;
    wait_cyc(3);
    chk({31'h0, we_n}, 32'h0);
    n_start = 32'(n_words);
    for (int i = 0; i < 4; i++)
    begin
      blk_send(32'ha5000000 + i, 40, ok);
      chk({31'h0, ok}, 32'h1);
    end
    wait_cyc(5);
    chk({24'h0, n_words}, 32'h4);
    chk(last_word, 32'ha5000003);
    // Wait reaches the stream only after synchronisation, so this word still passes.
    stall <= 1'b1;
    blk_send(32'ha5000004, 4, ok);
    chk({31'h0, ok}, 32'h1);
    wait_cyc(12);
    chk({24'h0, n_words}, 32'h5);
    blk_send(32'ha5000005, 30, ok);
    chk({31'h0, ok}, 32'h0);
    chk({24'h0, n_words}, 32'h5);
    stall <= 1'b0;
    blk_send(32'ha5000005, 60, ok);
    chk({31'h0, ok}, 32'h1);
    wait_cyc(6);
    chk({24'h0, n_words}, 32'h6);
    chk(last_word, 32'ha5000005);
    // Transfer length is the card's word count less its count at the start of the transfer.
    chk(32'(n_words) - n_start, 32'h6);
    blk_active <= 1'b0;
    wait_cyc(3);
    chk({31'h0, we_n}, 32'h1);
    final_report();
  end
  // Watchdog well beyond the expected run length.
  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end
endmodule : atdp_top_tb_top
`default_nettype wire
